// ### common/tiops_pkg.sv
// shared constants and types of the i/o port and mode select block
package tiops_pkg;

  localparam int          CLK_PERIOD_NS    = 4;
  // power-on mode selection window, in ns and in clock cycles
  localparam int          MODE_WIN_NS      = 1000000;
  localparam int          MODE_WIN_CYC_DEF = MODE_WIN_NS / CLK_PERIOD_NS;

  localparam int          NUM_PINS         = 4;
  localparam int          PIN_SCL          = 0;
  localparam int          PIN_SDA          = 1;
  localparam int          PIN_WAKE_RX      = 2;
  localparam int          PIN_TX           = 3;

  localparam logic [3:0]  DIR_RESET        = 4'h0;
  localparam logic [3:0]  OUT_RESET        = 4'h0;
  localparam logic [3:0]  SENS_RESET       = 4'hF;
  localparam logic [3:0]  SYNC_RESET       = 4'h0;

  // i2c slave address for mode commands (plain default)
  localparam logic [6:0]  MODE_I2C_ADDR    = 7'h2A;
  localparam logic [7:0]  CMD_NORMAL       = 8'h00;
  localparam logic [7:0]  CMD_PROGRAM      = 8'h01;
  localparam logic [7:0]  CMD_DEBUG        = 8'h02;
  localparam logic [7:0]  CMD_TEST         = 8'h03;

  typedef enum logic [1:0] {
    TIOPS_MODE_NORMAL  = 2'h0,
    TIOPS_MODE_PROGRAM = 2'h1,
    TIOPS_MODE_DEBUG   = 2'h2,
    TIOPS_MODE_TEST    = 2'h3
  } tiops_mode_t;

  typedef struct packed {
    logic       dir_wr;
    logic       out_wr;
    logic       sens_wr;
    logic [3:0] wdata;
  } tiops_sfr_wr_t;

  typedef struct packed {
    tiops_mode_t mode;
    logic        decided;
  } tiops_mode_stat_t;

endpackage

// ### hw/tiops_i2c_cmd.sv
// i2c slave that takes each write data byte after its address as a mode command
`timescale 1ns/1ns
module tiops_i2c_cmd
  import tiops_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_low,
  output logic            cmd_valid,
  output logic [7:0]      cmd_byte
);

  typedef enum logic [2:0] {
    TIOPS_I2C_IDLE = 3'h0,
    TIOPS_I2C_ADDR = 3'h1,
    TIOPS_I2C_AACK = 3'h3,
    TIOPS_I2C_DATA = 3'h2,
    TIOPS_I2C_DACK = 3'h6
  } tiops_i2c_st_t;

  tiops_i2c_st_t state_reg, state_next;
  logic          scl_q_reg, sda_q_reg;
  logic [2:0]    cnt_reg, cnt_next;
  logic [7:0]    shift_reg, shift_next;
  logic          done_reg, done_next;
  logic          low_reg, low_next;
  logic          valid_reg, valid_next;
  logic [7:0]    cmd_reg, cmd_next;

  ////////////////////////////////////////////////////////////////////////////
  // bus conditions; inputs are already filtered by the caller
  wire start_cond = scl & scl_q_reg & sda_q_reg & ~sda;
  wire stop_cond  = scl & scl_q_reg & ~sda_q_reg & sda;
  wire scl_rise   = scl & ~scl_q_reg;
  wire scl_fall   = ~scl & scl_q_reg;
  wire addr_hit   = (shift_reg[7:1] == MODE_I2C_ADDR) & ~shift_reg[0];

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    done_next  = done_reg;
    low_next   = low_reg;
    valid_next = 1'b0;
    cmd_next   = cmd_reg;
    if (!enable || stop_cond)
    begin
      state_next = TIOPS_I2C_IDLE;
      low_next   = 1'b0;
    end
    else if (start_cond)
    begin
      // repeated start restarts the address phase
      state_next = TIOPS_I2C_ADDR;
      cnt_next   = 3'h0;
      done_next  = 1'b0;
      low_next   = 1'b0;
    end
    else
    begin
      unique case (state_reg)
        TIOPS_I2C_IDLE: ;
        TIOPS_I2C_ADDR, TIOPS_I2C_DATA:
        begin
          if (scl_rise)
          begin
            shift_next = {shift_reg[6:0], sda};
            cnt_next   = cnt_reg + 3'h1;
            done_next  = (cnt_reg == 3'h7);
          end
          else if (scl_fall && done_reg)
          begin
            done_next = 1'b0;
            if (state_reg == TIOPS_I2C_DATA)
            begin
              cmd_next   = shift_reg;
              valid_next = 1'b1;
              low_next   = 1'b1;
              state_next = TIOPS_I2C_DACK;
            end
            else if (addr_hit)
            begin
              low_next   = 1'b1;
              state_next = TIOPS_I2C_AACK;
            end
            else
            begin
              state_next = TIOPS_I2C_IDLE;
            end
          end
        end
        TIOPS_I2C_AACK, TIOPS_I2C_DACK:
        begin
          // release sda when the acknowledge clock ends
          if (scl_fall)
          begin
            low_next   = 1'b0;
            state_next = TIOPS_I2C_DATA;
          end
        end
        default:
        begin
          state_next = TIOPS_I2C_IDLE;
          low_next   = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= TIOPS_I2C_IDLE;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      cnt_reg   <= 3'h0;
      shift_reg <= 8'h00;
      done_reg  <= 1'b0;
      low_reg   <= 1'b0;
      valid_reg <= 1'b0;
      cmd_reg   <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      scl_q_reg <= scl;
      sda_q_reg <= sda;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      done_reg  <= done_next;
      low_reg   <= low_next;
      valid_reg <= valid_next;
      cmd_reg   <= cmd_next;
    end
  end

  assign sda_low   = low_reg;
  assign cmd_valid = valid_reg;
  assign cmd_byte  = cmd_reg;

endmodule // tiops_i2c_cmd

// ### hw/tiops_port.sv
// four-pin i/o port with power-on i2c mode select, wake and uart pins
// Operation
// [RULE1] four pins with software direction, level, sensitivity
// [RULE2] pin zero is i2c clock, one data
// [RULE3] i2c interface follows fast-mode timing
// [RULE4] i2c enabled from power on
// [RULE5] i2c command in window picks operating mode
// [RULE6] no command before window end gives normal
// [RULE7] pin two level wakes or resumes device
// [RULE8] wake level selectable high or low
// [RULE9] wake source idles low, asserts high
// [RULE10] unused pins driven high, left open
// [RULE11] uart receive on pin two, transmit three
// [RULE12] alternate function overrides general purpose output
`timescale 1ns/1ns
module tiops_port
  import tiops_pkg::*;
#(
  parameter int MODE_WIN_CYC = MODE_WIN_CYC_DEF
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [3:0]       pin_in,
  output logic [3:0]            pin_out,
  output logic [3:0]            pin_oe,
  input  wire tiops_sfr_wr_t    sfr_wr,
  output logic [3:0]            port_direction_reg,
  output logic [3:0]            port_output_reg,
  output logic [3:0]            port_wake_sensitivity_reg,
  output logic [3:0]            port_input_reg,
  input  wire logic             i2c_release,
  input  wire logic             wake_en,
  input  wire logic             uart_en,
  input  wire logic             uart_txd,
  output logic                  uart_rxd,
  output logic                  wake_req,
  output logic                  i2c_active,
  output tiops_mode_stat_t      mode_stat
);

  localparam int CW = $clog2(MODE_WIN_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  if (MODE_WIN_CYC < 1)
  begin : g_bad_win
    $error("mode window must be at least one cycle");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic cmd_known(input logic [7:0] c);
    return (c == CMD_NORMAL) || (c == CMD_PROGRAM) ||
           (c == CMD_DEBUG) || (c == CMD_TEST);
  endfunction

  function automatic tiops_mode_t cmd_mode(input logic [7:0] c);
    return tiops_mode_t'(c[1:0]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser: three stages, change taken when two agree

  logic [3:0]       sync1_reg;
  logic [3:0]       sync2_reg;
  logic [3:0]       sync3_reg;
  logic [3:0]       filt_next;

  assign filt_next = (sync2_reg & sync3_reg) |
                     (port_input_reg & (sync2_reg ^ sync3_reg));

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync1_reg      <= SYNC_RESET;
      sync2_reg      <= SYNC_RESET;
      sync3_reg      <= SYNC_RESET;
      port_input_reg <= SYNC_RESET;
    end
    else
    begin
      sync1_reg      <= pin_in;
      sync2_reg      <= sync1_reg;
      sync3_reg      <= sync2_reg;
      port_input_reg <= filt_next; // [RULE1]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software-written port registers

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      port_direction_reg        <= DIR_RESET;
      port_output_reg           <= OUT_RESET;
      port_wake_sensitivity_reg <= SENS_RESET;
    end
    else
    begin
      if (sfr_wr.dir_wr)
        port_direction_reg <= sfr_wr.wdata; // [RULE1]
      if (sfr_wr.out_wr)
        port_output_reg <= sfr_wr.wdata; // [RULE1]
      if (sfr_wr.sens_wr)
        port_wake_sensitivity_reg <= sfr_wr.wdata; // [RULE1]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // i2c command receiver on pins zero and one

  logic             i2c_active_reg;
  logic             i2c_sda_low;
  logic             i2c_cmd_valid;
  logic [7:0]       i2c_cmd_byte;

  // no clock stretching, so the slave never pulls scl; this keeps it
  // inside fast-mode timing with the synchroniser latency of 16 ns
  tiops_i2c_cmd u_i2c (
    .clk       (clk),
    .rst_n     (rst_n),
    .enable    (i2c_active_reg),
    .scl       (port_input_reg[PIN_SCL]), // [RULE2]
    .sda       (port_input_reg[PIN_SDA]), // [RULE2]
    .sda_low   (i2c_sda_low), // [RULE3]
    .cmd_valid (i2c_cmd_valid),
    .cmd_byte  (i2c_cmd_byte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // power-on mode selection window

  logic [CW-1:0]    win_cnt_reg;
  logic [CW-1:0]    win_cnt_next;
  logic             decided_reg;
  logic             decided_next;
  tiops_mode_t      mode_reg;
  tiops_mode_t      mode_next;
  logic             i2c_active_next;

  wire cmd_take   = i2c_cmd_valid & ~decided_reg & cmd_known(i2c_cmd_byte);
  wire win_expire = ~decided_reg & (win_cnt_reg == '0);

  always_comb
  begin
    win_cnt_next = win_cnt_reg;
    decided_next = decided_reg;
    mode_next    = mode_reg;
    if (cmd_take)
    begin
      mode_next    = cmd_mode(i2c_cmd_byte); // [RULE5]
      decided_next = 1'b1;
    end
    else if (win_expire)
    begin
      mode_next    = TIOPS_MODE_NORMAL; // [RULE6]
      decided_next = 1'b1;
    end
    else if (!decided_reg)
    begin
      win_cnt_next = win_cnt_reg - CW'(1);
    end
  end

  // software may hand pins zero and one back once the mode is fixed
  assign i2c_active_next = i2c_active_reg & ~(i2c_release & decided_reg);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      win_cnt_reg    <= CW'(MODE_WIN_CYC - 1);
      decided_reg    <= 1'b0;
      mode_reg       <= TIOPS_MODE_NORMAL;
      i2c_active_reg <= 1'b1; // [RULE4]
    end
    else
    begin
      win_cnt_reg    <= win_cnt_next;
      decided_reg    <= decided_next;
      mode_reg       <= mode_next;
      i2c_active_reg <= i2c_active_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive selection

  logic [3:0]       out_next;
  logic [3:0]       oe_next;

  // i2c pins are open drain: level low, enable only while pulling down
  assign out_next[PIN_SCL] = i2c_active_reg ?
                             1'b0 : port_output_reg[PIN_SCL]; // [RULE12]
  assign oe_next[PIN_SCL]  = i2c_active_reg ?
                             1'b0 : port_direction_reg[PIN_SCL]; // [RULE12]
  assign out_next[PIN_SDA] = i2c_active_reg ?
                             1'b0 : port_output_reg[PIN_SDA]; // [RULE12]
  assign oe_next[PIN_SDA]  = i2c_active_reg ?
                             i2c_sda_low :
                             port_direction_reg[PIN_SDA]; // [RULE2]
  assign out_next[PIN_WAKE_RX] = port_output_reg[PIN_WAKE_RX];
  assign oe_next[PIN_WAKE_RX]  = uart_en ?
                                 1'b0 :
                                 port_direction_reg[PIN_WAKE_RX]; // [RULE11]
  assign out_next[PIN_TX] = uart_en ?
                            uart_txd : port_output_reg[PIN_TX]; // [RULE11]
  assign oe_next[PIN_TX]  = uart_en ?
                            1'b1 : port_direction_reg[PIN_TX]; // [RULE12]

  ////////////////////////////////////////////////////////////////////////////
  // wake and uart receive

  logic             wake_next;
  logic             rxd_next;
  logic             wake_reg;
  logic             rxd_reg;

  // high-level wake costs more leakage; the low idle level is the user's
  assign wake_next = wake_en & // [RULE7]
                     (port_input_reg[PIN_WAKE_RX] ==
                      port_wake_sensitivity_reg[PIN_WAKE_RX]); // [RULE8]
  assign rxd_next  = uart_en ?
                     port_input_reg[PIN_WAKE_RX] : 1'b1; // [RULE11]

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pin_out  <= OUT_RESET;
      pin_oe   <= DIR_RESET;
      wake_reg <= 1'b0;
      rxd_reg  <= 1'b1;
    end
    else
    begin
      pin_out  <= out_next;
      pin_oe   <= oe_next;
      wake_reg <= wake_next;
      rxd_reg  <= rxd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign wake_req          = wake_reg;
  assign uart_rxd          = rxd_reg;
  assign i2c_active        = i2c_active_reg;
  assign mode_stat         = '{mode: mode_reg, decided: decided_reg};

endmodule // tiops_port

// ### testbench/tiops_port_sva.sv
// assertion checker for the i/o port and mode select block
`timescale 1ns/1ns
module tiops_port_sva
  import tiops_pkg::*;
#(
  parameter int MODE_WIN_CYC = MODE_WIN_CYC_DEF
)
(
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic [3:0]       pin_out,
  input wire logic [3:0]       pin_oe,
  input wire logic [3:0]       port_direction_reg,
  input wire logic [3:0]       port_output_reg,
  input wire logic [3:0]       port_wake_sensitivity_reg,
  input wire logic [3:0]       port_input_reg,
  input wire logic             wake_en,
  input wire logic             uart_en,
  input wire logic             uart_txd,
  input wire logic             uart_rxd,
  input wire logic             wake_req,
  input wire logic             i2c_active,
  input wire tiops_mode_stat_t mode_stat
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  int win_cnt_reg;
  // saturates, so a long run never wraps below the window
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      win_cnt_reg <= 0;
    else if (win_cnt_reg < MODE_WIN_CYC)
      win_cnt_reg <= win_cnt_reg + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_i2c_opendrain: assert property (i2c_active |-> !pin_oe[0] &&
    (!pin_oe[1] || !pin_out[1])) else $error("i2c pin driven high");
  a_release_late: assert property ($fell(i2c_active) |->
    mode_stat.decided) else $error("i2c released before mode");
  a_active_stays: assert property (!i2c_active |=>
    !i2c_active) else $error("i2c came back");
  a_mode_hold: assert property (mode_stat.decided |=>
    mode_stat.decided && $stable(mode_stat.mode)) else $error("mode moved");
  a_win_expire: assert property (win_cnt_reg >= MODE_WIN_CYC |->
    mode_stat.decided) else $error("window overran");
  a_wake_gate: assert property (!wake_en |=>
    !wake_req) else $error("wake while disabled");
  a_wake_level: assert property (wake_req |->
    $past(port_input_reg[2] == port_wake_sensitivity_reg[2]))
    else $error("wake on wrong level");
  a_uart_pins: assert property (uart_en |=>
    !pin_oe[2] && pin_oe[3] && pin_out[3] == $past(uart_txd))
    else $error("uart pins wrong");
  a_rx_idle: assert property (!uart_en |=>
    uart_rxd) else $error("rx not idle");
  a_gpio_pin: assert property (!uart_en |=>
    pin_oe[3] == $past(port_direction_reg[3]) &&
    (!pin_oe[3] || pin_out[3] == $past(port_output_reg[3])))
    else $error("pin three not gpio");
endmodule // tiops_port_sva

bind tiops_port tiops_port_sva #(.MODE_WIN_CYC(MODE_WIN_CYC)) i_tiops_port_sva
(
  .clk(clk), .rst_n(rst_n), .pin_out(pin_out), .pin_oe(pin_oe),
  .port_direction_reg(port_direction_reg),
  .port_output_reg(port_output_reg),
  .port_wake_sensitivity_reg(port_wake_sensitivity_reg),
  .port_input_reg(port_input_reg), .wake_en(wake_en), .uart_en(uart_en),
  .uart_txd(uart_txd), .uart_rxd(uart_rxd), .wake_req(wake_req),
  .i2c_active(i2c_active), .mode_stat(mode_stat)
);

// ### testbench/tiops_i2c_host.sv
// i2c host model that picks the operating mode after power on
`timescale 1ns/1ns
module tiops_i2c_host
(
  input  wire logic clk,
  input  wire logic sda_in,
  output logic      scl_low,
  output logic      sda_low
);
  // 1.6 us low, 0.96 us high: just under 400 kHz
  localparam int T_LO = 400;
  localparam int T_HI = 240;
  initial
  begin
    scl_low = 0;
    sda_low = 0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // data moves well inside scl low so no false start or stop
  task automatic bitx(input logic b, output logic r);
    wt(40);
    sda_low <= !b;
    wt(T_LO - 40);
    scl_low <= 0;
    wt(T_HI / 2);
    r = sda_in;
    wt(T_HI / 2);
    scl_low <= 1;
  endtask
  // one write: address byte then command byte
  task automatic send(input logic [7:0] adr, input logic [7:0] cmd,
                      output logic ack_a, output logic ack_c);
    logic r;
    ack_c = 0;
    wt(20);
    sda_low <= 1;
    wt(T_HI);
    scl_low <= 1;
    for (int i = 7; i >= 0; i--)
      bitx(adr[i], r);
    bitx(1'b1, r);
    ack_a = !r;
    if (ack_a)
    begin
      for (int i = 7; i >= 0; i--)
        bitx(cmd[i], r);
      bitx(1'b1, r);
      ack_c = !r;
    end
    wt(40);
    sda_low <= 1;
    wt(T_LO);
    scl_low <= 0;
    wt(T_HI);
    sda_low <= 0;
    // bus free time before any next start stays above 1.3 us
    wt(T_LO);
  endtask
endmodule // tiops_i2c_host

// ### testbench/tiops_port_test.sv
// self-checking bench of the i/o port and mode select block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module tiops_port_test;
  import tiops_pkg::*;
  // short window keeps the run small; a command still fits inside
  localparam int WIN = 22000;
  logic             clk, rst_n, i2c_release, wake_en, uart_en, uart_txd;
  logic             ext2, ext3, uart_rxd, wake_req, i2c_active;
  logic             scl_low, sda_low;
  logic [3:0]       pin_out, pin_oe, dir_q, out_q, sens_q, in_q;
  wire logic [3:0]  pin_in;
  tiops_sfr_wr_t    sfr_wr;
  tiops_mode_stat_t mode_stat;
  int               n_mismatch = 0;
  int               n_checks = 0;
  int               cyc = 0;
  // pull-ups on the i2c pair; the host only ever pulls low there, and a port drive high reads as the pull-up
  assign pin_in = {pin_oe[3] ? pin_out[3] : ext3,
                   pin_oe[2] ? pin_out[2] : ext2,
                   !sda_low && (!pin_oe[1] || pin_out[1]),
                   !scl_low && (!pin_oe[0] || pin_out[0])};
  tiops_port #(.MODE_WIN_CYC(WIN)) i_tiops_port
  (
    .clk(clk), .rst_n(rst_n), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .sfr_wr(sfr_wr), .port_direction_reg(dir_q),
    .port_output_reg(out_q), .port_wake_sensitivity_reg(sens_q),
    .port_input_reg(in_q), .i2c_release(i2c_release), .wake_en(wake_en),
    .uart_en(uart_en), .uart_txd(uart_txd), .uart_rxd(uart_rxd),
    .wake_req(wake_req), .i2c_active(i2c_active), .mode_stat(mode_stat)
  );
  tiops_i2c_host i_tiops_i2c_host
  (
    .clk(clk), .sda_in(pin_in[1]), .scl_low(scl_low), .sda_low(sda_low)
  );
  initial
  begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
    cyc <= rst_n ? cyc + 1 : 0;
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset();
    @(posedge clk) rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
  endtask
  task automatic wr(input logic d, o, s, input logic [3:0] v);
    @(posedge clk) sfr_wr <= '{d, o, s, v};
    @(posedge clk) sfr_wr <= '0;
  endtask
  task automatic t_mode(input logic [7:0] code, input tiops_mode_t m);
    logic aa, ac;
    do_reset();
    tick(1);
    `CHK("i2c on", 1'b1, i2c_active)
    `CHK("sens rst", 4'hF, sens_q)
    `CHK("dir rst", 4'h0, dir_q)
    i_tiops_i2c_host.send({MODE_I2C_ADDR, 1'b0}, code, aa, ac);
    tick(1);
    `CHK("addr ack", 1'b1, aa)
    `CHK("cmd ack", 1'b1, ac)
    `CHK("decided", 1'b1, mode_stat.decided)
    `CHK("mode", m, mode_stat.mode)
    $display("mode test done");
  endtask
  task automatic t_window();
    logic aa, ac;
    do_reset();
    // an unknown code is acknowledged but must not fix the mode
    i_tiops_i2c_host.send({MODE_I2C_ADDR, 1'b0}, 8'h04, aa, ac);
    `CHK("odd ack", 1'b1, ac)
    `CHK("odd cmd", 1'b0, mode_stat.decided)
    i_tiops_i2c_host.send({MODE_I2C_ADDR + 7'h01, 1'b0}, CMD_DEBUG, aa, ac);
    `CHK("foreign ack", 1'b0, aa)
    while (cyc < WIN - 20) @(posedge clk);
    #1;
    `CHK("early", 1'b0, mode_stat.decided)
    while (cyc < WIN + 20) @(posedge clk);
    #1;
    `CHK("expired", 1'b1, mode_stat.decided)
    `CHK("normal", TIOPS_MODE_NORMAL, mode_stat.mode)
    $display("window test done");
  endtask
  task automatic t_gpio();
    @(posedge clk) i2c_release <= 1;
    @(posedge clk) i2c_release <= 0;
    wr(1, 1, 0, 4'hF);
    tick(3);
    `CHK("released", 1'b0, i2c_active)
    `CHK("all out", 4'hF, pin_oe)
    `CHK("all high", 4'hF, pin_out)
    wr(0, 1, 0, 4'h5);
    wr(1, 0, 0, 4'h0);
    tick(8);
    `CHK("out reg", 4'h5, out_q)
    `CHK("inputs", 1'b0, |pin_oe)
    `CHK("in reg", 4'h3, in_q)
    $display("gpio test done");
  endtask
  task automatic t_wake();
    @(posedge clk) wake_en <= 1;
    tick(8);
    `CHK("wake idle", 1'b0, wake_req)
    @(posedge clk) ext2 <= 1;
    tick(8);
    `CHK("wake high", 1'b1, wake_req)
    wr(0, 0, 1, 4'h0);
    tick(3);
    `CHK("sens low", 1'b0, wake_req)
    @(posedge clk) ext2 <= 0;
    tick(8);
    `CHK("wake low", 1'b1, wake_req)
    @(posedge clk) wake_en <= 0;
    tick(3);
    `CHK("wake off", 1'b0, wake_req)
    $display("wake test done");
  endtask
  task automatic t_uart();
    wr(1, 0, 0, 4'hF);
    @(posedge clk) uart_en <= 1;
    uart_txd <= 1;
    tick(8);
    `CHK("tx drive", 1'b1, pin_oe[3] & pin_out[3])
    `CHK("rx pin", 1'b0, pin_oe[2])
    `CHK("rx low", 1'b0, uart_rxd)
    @(posedge clk) uart_txd <= 0;
    ext2 <= 1;
    tick(8);
    `CHK("tx low", 1'b0, pin_out[3])
    `CHK("rx high", 1'b1, uart_rxd)
    @(posedge clk) uart_en <= 0;
    uart_txd <= 1;
    tick(3);
    `CHK("gpio back", 1'b0, pin_out[3])
    $display("uart test done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    $display("[ERR] watchdog expired");
    finish_test();
  end
  initial
  begin
    {rst_n, i2c_release, wake_en, uart_en, uart_txd, ext3} = '0;
    ext2 = 0; // wake source idles low
    sfr_wr = '0;
    t_mode(CMD_NORMAL, TIOPS_MODE_NORMAL);
    t_mode(CMD_PROGRAM, TIOPS_MODE_PROGRAM);
    t_mode(CMD_DEBUG, TIOPS_MODE_DEBUG);
    t_mode(CMD_TEST, TIOPS_MODE_TEST);
    t_window();
    t_gpio();
    t_wake();
    t_uart();
    finish_test();
  end
endmodule // tiops_port_test
